// ===== core/csd_top.sv
// Chip-select option decoder for the boot channel with discrete output latch and Wishbone registers
//
// Summary of operation
// - The lane field disables the select (00) or matches lower (01), upper (10) or both (11) byte lanes.
// - The direction field matches reads only (01), writes only (10) or both (11); 00 never matches.
// - In asynchronous mode the select is timed by the address strobe (bit 0) or the data strobe (bit 1).
// - The strobe-timing bit is ignored when the channel is synchronized to the slow bus clock.
// - Acknowledge codes 0 to 13 make the acknowledge internally after that many wait states.
// - Code 1110 terminates fast; code 1111 leaves the acknowledge to the external device.
// - The space field matches CPU (00), user (01), supervisor (10) or supervisor and user (11) accesses.
// - In CPU space the level field picks the interrupt level, 000 matching every level.
// - In user or supervisor space the level field picks data, program or either; 011, 100, 111 never match.
// - With autovector enabled, a matching acknowledge cycle started by a request pin raises autovector.
// - The discrete latch is read/write and each bit drives its pin when the pin is a discrete output.
// - Bit 7 of the discrete latch ignores writes and reads as zero.
// - Lane matches use the internal lowest address bit.
// - After reset the boot channel decodes base zero with a 1 Mbyte block.
// - Timing-mode 0 emulates asynchronous timing; 1 synchronizes assertion to the slow bus clock.
// - The address is compared with the base field over a block whose size the block-size field sets.
`timescale 1ns/1ps
`include "csd_consts.svh"
module csd_top (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Internal bus cycle
	input wire logic bus_cycle_i,
	input wire logic [23:0] bus_addr_i,
	input wire logic bus_byte_i,
	input wire logic bus_read_i,
	input wire logic bus_cpu_space_i,
	input wire logic bus_super_i,
	input wire logic bus_program_i,
	input wire logic [2:0] bus_iack_level_i,
	input wire logic bus_iack_pin_i,
	input wire logic bus_as_i,
	input wire logic bus_ds_i,
	input wire logic slow_bus_clock_i,
	// External acknowledge pin, active low, asynchronous
	input wire logic ext_ack_n_i,
	// Results toward the bus and the pins
	output logic boot_select_out_n_o,
	output logic transfer_ack_o,
	output logic autovec_o,
	output logic [`CSD_DOUT_W-1:0] discrete_out_o,
	output logic [`CSD_DOUT_W-1:0] discrete_oe_o
);
	logic [15:0] option;
	logic [15:0] base;
	logic [`CSD_DOUT_W-1:0] discrete_out_latch;
	logic [`CSD_DOUT_W-1:0] pin_assign;
	csd_pkg::csd_state_type state;
	logic [3:0] wait_cnt;
	logic ext_s1;
	logic ext_s2;
	logic ext_s3;
	logic ext_ack_n;
	logic match;
	logic strobe_ok;
	logic next_select;
	logic wb_req;
	logic [3:0] ack_code;
	logic [31:0] next_dat;

	assign ack_code = option[`CSD_OPT_ACK_HI:`CSD_OPT_ACK_LO];
	assign wb_req = cyc_i & stb_i & ~ack_o;

	// Field decode lives in the match block so the sequencing here stays readable
	csd_match u_match (
		.option_i(option),
		.base_i(base),
		.addr_i(bus_addr_i),
		.byte_access_i(bus_byte_i),
		.read_i(bus_read_i),
		.cpu_space_i(bus_cpu_space_i),
		.super_i(bus_super_i),
		.program_i(bus_program_i),
		.iack_level_i(bus_iack_level_i),
		.match_o(match)
	);

	// Which edge of the cycle may open the select
	always_comb begin
		if (option[`CSD_OPT_MODE]) begin
			strobe_ok = slow_bus_clock_i;
		end else if (option[`CSD_OPT_STROBE_TIMING_SELECT]) begin
			strobe_ok = bus_ds_i;
		end else begin
			strobe_ok = bus_as_i;
		end
	end

	assign next_select = bus_cycle_i & match & strobe_ok;

	// External acknowledge pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_s3 <= 1'b1;
			ext_ack_n <= 1'b1;
		end else begin
			ext_s1 <= ext_ack_n_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			if (ext_s2 == ext_s3) begin
				ext_ack_n <= ext_s3;
			end
		end
	end

	// Select and acknowledge sequencer; one select per bus cycle, held until the cycle ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= csd_pkg::CSD_IDLE;
			wait_cnt <= 4'h0;
			boot_select_out_n_o <= 1'b1;
			transfer_ack_o <= 1'b0;
			autovec_o <= 1'b0;
		end else begin
			case (state)
				csd_pkg::CSD_IDLE: begin
					if (next_select) begin
						boot_select_out_n_o <= 1'b0;
						wait_cnt <= ack_code;
						// Autovector only for pin-started acknowledge cycles
						autovec_o <= option[`CSD_OPT_AUTOVEC_ENABLE] & bus_cpu_space_i & bus_iack_pin_i;
						if (ack_code == `CSD_ACK_FAST) begin
							transfer_ack_o <= 1'b1;
							state <= csd_pkg::CSD_DONE;
						end else begin
							state <= csd_pkg::CSD_WAIT;
						end
					end
				end
				csd_pkg::CSD_WAIT: begin
					if (!bus_cycle_i) begin
						// Cycle aborted before acknowledge
						boot_select_out_n_o <= 1'b1;
						autovec_o <= 1'b0;
						state <= csd_pkg::CSD_IDLE;
					end else if (ack_code == `CSD_ACK_EXT) begin
						// Device supplies its own acknowledge; we only stay selected
						if (!ext_ack_n) begin
							state <= csd_pkg::CSD_DONE;
						end
					end else if (wait_cnt == 4'h0) begin
						transfer_ack_o <= 1'b1;
						state <= csd_pkg::CSD_DONE;
					end else begin
						wait_cnt <= wait_cnt - 4'h1;
					end
				end
				csd_pkg::CSD_DONE: begin
					if (!bus_cycle_i) begin
						boot_select_out_n_o <= 1'b1;
						transfer_ack_o <= 1'b0;
						autovec_o <= 1'b0;
						state <= csd_pkg::CSD_IDLE;
					end
				end
				default: begin
					boot_select_out_n_o <= 1'b1;
					transfer_ack_o <= 1'b0;
					autovec_o <= 1'b0;
					state <= csd_pkg::CSD_IDLE;
				end
			endcase
		end
	end

	// Option and base registers; reset values give the boot channel its first-fetch window
	// Writes land at the edge where the master sees ack, so an abandoned request leaves no trace
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			option <= `CSD_OPTION_RST;
			base <= `CSD_BASE_RST;
		end else if (cyc_i && stb_i && we_i && ack_o) begin
			if (adr_i == `CSD_OFF_OPTION) begin
				if (sel_i[0]) option[7:0] <= dat_i[7:0];
				if (sel_i[1]) option[15:8] <= dat_i[15:8];
			end
			if (adr_i == `CSD_OFF_BASE) begin
				if (sel_i[0]) base[7:0] <= dat_i[7:0];
				if (sel_i[1]) base[15:8] <= dat_i[15:8];
			end
		end
	end

	// Discrete latch and pin assignment; bit 7 has no storage so writes to it vanish
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			discrete_out_latch <= `CSD_DOUT_RST;
			pin_assign <= `CSD_PINASG_RST;
		end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0]) begin
			if (adr_i == `CSD_OFF_DOUT) begin
				discrete_out_latch <= dat_i[`CSD_DOUT_W-1:0];
			end
			if (adr_i == `CSD_OFF_PINASG) begin
				pin_assign <= dat_i[`CSD_DOUT_W-1:0];
			end
		end
	end

	// Each discrete pin follows its latch bit only while assigned as an output
	genvar gi;
	generate
		for (gi = 0; gi < `CSD_DOUT_W; gi++) begin : g_dout
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					discrete_out_o[gi] <= 1'b0;
					discrete_oe_o[gi] <= 1'b0;
				end else begin
					discrete_out_o[gi] <= pin_assign[gi] & discrete_out_latch[gi];
					discrete_oe_o[gi] <= pin_assign[gi];
				end
			end
		end
	endgenerate

	// Read mux; unmapped offsets answer with zero
	always_comb begin
		next_dat = 32'h0000_0000;
		case (adr_i)
			`CSD_OFF_OPTION: next_dat = {16'h0000, option};
			`CSD_OFF_BASE: next_dat = {16'h0000, base};
			`CSD_OFF_DOUT: next_dat = {24'h00_0000, 1'b0, discrete_out_latch};
			`CSD_OFF_PINASG: next_dat = {25'h000_0000, pin_assign};
			`CSD_OFF_STATUS: next_dat = {22'h00_0000, state, wait_cnt, ~ext_ack_n,
				autovec_o, transfer_ack_o, ~boot_select_out_n_o};
			default: next_dat = 32'h0000_0000;
		endcase
	end

	// Single-wait Wishbone answer: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= wb_req;
			if (wb_req && !we_i) begin
				dat_o <= next_dat;
			end
		end
	end
endmodule

// ===== core/csd_consts.svh
// Register offsets, field positions, reset values and widths of the chip-select option decoder
`ifndef CSD_CONSTS_SVH
`define CSD_CONSTS_SVH

// Wishbone word offsets (byte addresses)
`define CSD_OFF_OPTION 8'h00
`define CSD_OFF_BASE 8'h04
`define CSD_OFF_DOUT 8'h08
`define CSD_OFF_PINASG 8'h0c
`define CSD_OFF_STATUS 8'h10

// Option register fields
`define CSD_OPT_MODE 15
`define CSD_OPT_LANE_HI 14
`define CSD_OPT_LANE_LO 13
`define CSD_OPT_DIR_HI 12
`define CSD_OPT_DIR_LO 11
`define CSD_OPT_STROBE_TIMING_SELECT 10
`define CSD_OPT_ACK_HI 9
`define CSD_OPT_ACK_LO 6
`define CSD_OPT_SPACE_HI 5
`define CSD_OPT_SPACE_LO 4
`define CSD_OPT_LEVEL_HI 3
`define CSD_OPT_LEVEL_LO 1
`define CSD_OPT_AUTOVEC_ENABLE 0

// Base register fields: base address bits 23..11 in 15..3, block size in 2..0
`define CSD_BASE_ADDR_HI 15
`define CSD_BASE_ADDR_LO 3
`define CSD_BASE_BLK_HI 2

// Reset values of the boot channel and the discrete latch
`define CSD_OPTION_RST 16'h7b70
`define CSD_BASE_RST 16'h0007
`define CSD_DOUT_RST 7'h7f
`define CSD_PINASG_RST 7'h00

// Acknowledge codes
`define CSD_ACK_FAST 4'he
`define CSD_ACK_EXT 4'hf

// Width of the discrete output latch
`define CSD_DOUT_W 7

`endif

// ===== core/csd_pkg.sv
// Types shared by the chip-select option decoder
package csd_pkg;

	typedef enum logic [1:0] {
		CSD_IDLE = 2'b00,
		CSD_WAIT = 2'b01,
		CSD_DONE = 2'b10
	} csd_state_type;

	typedef enum logic [1:0] {
		CSD_SP_CPU = 2'b00,
		CSD_SP_USER = 2'b01,
		CSD_SP_SUPER = 2'b10,
		CSD_SP_BOTH = 2'b11
	} csd_space_type;

endpackage

// ===== core/csd_match.sv
// Combinational match of one access against the base and option fields of a channel
`timescale 1ns/1ps
module csd_match (
	input wire logic [15:0] option_i,
	input wire logic [15:0] base_i,
	input wire logic [23:0] addr_i,
	input wire logic byte_access_i,
	input wire logic read_i,
	input wire logic cpu_space_i,
	input wire logic super_i,
	input wire logic program_i,
	input wire logic [2:0] iack_level_i,
	output logic match_o
);
	logic [1:0] lane;
	logic [1:0] dir;
	logic [1:0] space;
	logic [2:0] level;
	logic [2:0] blk;
	logic [12:0] cmp_mask;
	logic addr_ok;
	logic lane_ok;
	logic dir_ok;
	logic space_ok;
	logic level_ok;

	assign lane = option_i[`CSD_OPT_LANE_HI:`CSD_OPT_LANE_LO];
	assign dir = option_i[`CSD_OPT_DIR_HI:`CSD_OPT_DIR_LO];
	assign space = option_i[`CSD_OPT_SPACE_HI:`CSD_OPT_SPACE_LO];
	assign level = option_i[`CSD_OPT_LEVEL_HI:`CSD_OPT_LEVEL_LO];
	assign blk = base_i[`CSD_BASE_BLK_HI:0];

	// Block size picks how many address bits above bit 10 are ignored
	always_comb begin
		case (blk)
			3'h0: cmp_mask = 13'h1fff;
			3'h1: cmp_mask = 13'h1ffc;
			3'h2: cmp_mask = 13'h1ff8;
			3'h3: cmp_mask = 13'h1fe0;
			3'h4: cmp_mask = 13'h1fc0;
			3'h5: cmp_mask = 13'h1f80;
			3'h6: cmp_mask = 13'h1f00;
			default: cmp_mask = 13'h1e00;
		endcase
	end

	// Base compare on the masked upper address
	assign addr_ok = ((addr_i[23:11] ^ base_i[`CSD_BASE_ADDR_HI:`CSD_BASE_ADDR_LO]) & cmp_mask) == 13'h0000;

	// Internal lowest address bit decides the lane, so the pin need not reach memory
	always_comb begin
		case (lane)
			2'b01: lane_ok = byte_access_i ? addr_i[0] : 1'b1;
			2'b10: lane_ok = byte_access_i ? ~addr_i[0] : 1'b1;
			2'b11: lane_ok = 1'b1;
			default: lane_ok = 1'b0;
		endcase
	end

	// Direction filter; the reserved code never matches
	always_comb begin
		case (dir)
			2'b01: dir_ok = read_i;
			2'b10: dir_ok = ~read_i;
			2'b11: dir_ok = 1'b1;
			default: dir_ok = 1'b0;
		endcase
	end

	// Address space filter
	always_comb begin
		case (space)
			2'b00: space_ok = cpu_space_i;
			2'b01: space_ok = ~cpu_space_i & ~super_i;
			2'b10: space_ok = ~cpu_space_i & super_i;
			default: space_ok = ~cpu_space_i;
		endcase
	end

	// Level field: interrupt level in CPU space, data/program class otherwise
	always_comb begin
		if (space == 2'b00) begin
			level_ok = (level == 3'h0) || (level == iack_level_i);
		end else begin
			case (level)
				3'h0: level_ok = 1'b1;
				3'h1, 3'h5: level_ok = ~program_i;
				3'h2, 3'h6: level_ok = program_i;
				default: level_ok = 1'b0;
			endcase
		end
	end

	// All conditions at once
	assign match_o = addr_ok & lane_ok & dir_ok & space_ok & level_ok;
endmodule

// ===== dv/csd_monitor.sv
// Port-level assertion checker for the chip-select option decoder
`timescale 1ns/1ps
module csd_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic bus_cycle_i,
	input wire logic bus_read_i,
	input wire logic bus_cpu_space_i,
	input wire logic bus_iack_pin_i,
	input wire logic boot_select_out_n_o,
	input wire logic transfer_ack_o,
	input wire logic autovec_o
);
	logic [15:0] opt;
	logic [4:0] cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the option register, since the codes are not visible at the ports
	always_ff @(posedge clk_i) begin
		if (rst_i)
			opt <= 16'h7b70;
		else if (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00) begin
			if (sel_i[0])
				opt[7:0] <= dat_i[7:0];
			if (sel_i[1])
				opt[15:8] <= dat_i[15:8];
		end
	end
	// Cycles spent selected; saturates so a stuck select cannot wrap
	always_ff @(posedge clk_i) begin
		if (rst_i || boot_select_out_n_o)
			cnt <= 5'h00;
		else if (cnt != 5'h1f)
			cnt <= cnt + 5'h01;
	end
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_bit7_zero: assert property (ack_o && !we_i && adr_i == 8'h08 |-> !dat_o[7]) else $error("bit 7 set");
	a_lane_off: assert property (boot_select_out_n_o && opt[14:13] == 2'b00 |=> boot_select_out_n_o)
		else $error("select with lanes off");
	a_dir_write: assert property (boot_select_out_n_o && !bus_read_i && !opt[12] |=> boot_select_out_n_o)
		else $error("write selected");
	a_space_cpu: assert property (boot_select_out_n_o && bus_cpu_space_i && opt[5:4] != 2'b00 |=>
		boot_select_out_n_o) else $error("cpu space selected");
	a_no_cycle: assert property (!bus_cycle_i |=> boot_select_out_n_o) else $error("select outside cycle");
	a_fast_term: assert property ($fell(boot_select_out_n_o) && opt[9:6] == 4'he |-> transfer_ack_o)
		else $error("fast ack late");
	a_wait_count: assert property ($rose(transfer_ack_o) && opt[9:6] < 4'he |->
		cnt == {1'b0, opt[9:6]} + 5'h01) else $error("wrong wait count");
	a_ext_ack: assert property ($rose(transfer_ack_o) |-> opt[9:6] != 4'hf) else $error("ack in ext mode");
	a_autovec_enable_cause: assert property ($rose(autovec_o) |-> opt[0] && bus_cpu_space_i && bus_iack_pin_i)
		else $error("stray autovector");
	cover property ($rose(transfer_ack_o) && opt[9:6] == 4'hd);
	cover property ($rose(autovec_o));
	cover property ($fell(boot_select_out_n_o) && opt[15]);
endmodule
bind csd_top csd_monitor csd_monitor_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
	.ack_o, .bus_cycle_i, .bus_read_i, .bus_cpu_space_i, .bus_iack_pin_i, .boot_select_out_n_o, .transfer_ack_o,
	.autovec_o);

// ===== dv/csd_ext_dev.sv
// Model of an external device that returns its own acknowledge
`timescale 1ns/1ps
module csd_ext_dev (
	input wire logic clk_i,
	input wire logic select_n_i,
	input wire logic [3:0] delay_i,
	output logic ack_n_o
);
	logic [3:0] cnt;
	// Access time since select; the model drives the pin high when released
	always_ff @(posedge clk_i) begin
		if (select_n_i)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	end
	assign ack_n_o = !(!select_n_i && cnt >= delay_i);
endmodule

// ===== dv/tb.sv
// Self-checking bench for the chip-select option decoder
`timescale 1ns/1ps
module tb;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, bus_cycle_i, bus_byte_i, bus_read_i, bus_cpu_space_i;
	logic bus_super_i, bus_program_i, bus_iack_pin_i, bus_as_i, bus_ds_i, slow_bus_clock_i, ext_ack_n_i;
	logic boot_select_out_n_o, transfer_ack_o, autovec_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i, dly;
	logic [31:0] dat_i, dat_o, rd;
	logic [23:0] bus_addr_i;
	logic [2:0] bus_iack_level_i;
	logic [6:0] discrete_out_o, discrete_oe_o;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	csd_top csd_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .bus_cycle_i,
		.bus_addr_i, .bus_byte_i, .bus_read_i, .bus_cpu_space_i, .bus_super_i, .bus_program_i, .bus_iack_level_i,
		.bus_iack_pin_i, .bus_as_i, .bus_ds_i, .slow_bus_clock_i, .ext_ack_n_i, .boot_select_out_n_o,
		.transfer_ack_o, .autovec_o, .discrete_out_o, .discrete_oe_o);
	csd_ext_dev csd_ext_dev_i (.clk_i, .select_n_i(boot_select_out_n_o), .delay_i(dly), .ack_n_o(ext_ack_n_i));
	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	function int sx(input logic m);
		return m ? 2 : 0;
	endfunction
	// Classic single Wishbone cycle; read data is taken at the ack edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// No fixed wait assumed; only the hang guard ends a missing ack
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// One bus cycle: data strobe and slow clock rise d edges late; indices count edges from the start
	task bg(input logic [23:0] a, input logic b, input logic r, input int d, input int es, input int ea,
		input logic ev);
		int si;
		int ai;
		logic av;
		si = 0;
		ai = 0;
		av = 1'b0;
		@(posedge clk_i);
		bus_addr_i <= a;
		bus_byte_i <= b;
		bus_read_i <= r;
		bus_cycle_i <= 1'b1;
		bus_as_i <= 1'b1;
		bus_ds_i <= d == 0;
		slow_bus_clock_i <= d == 0;
		for (int i = 1; i < 20; i++) begin
			@(posedge clk_i);
			if (si == 0 && boot_select_out_n_o === 1'b0)
				si = i;
			if (ai == 0 && transfer_ack_o === 1'b1)
				ai = i;
			if (autovec_o === 1'b1)
				av = 1'b1;
			if (i == d) begin
				bus_ds_i <= 1'b1;
				slow_bus_clock_i <= 1'b1;
			end
		end
		bus_cycle_i <= 1'b0;
		bus_as_i <= 1'b0;
		bus_ds_i <= 1'b0;
		slow_bus_clock_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(32'(si), 32'(es));
		chk(32'(ai), 32'(ea));
		chk(32'(av), 32'(ev));
		chk(32'(boot_select_out_n_o), 32'h1);
	endtask
	// Reset values, unmapped space, dead latch bit, discrete pins, boot window
	task t_regs();
		logic [31:0] rv [4];
		rv = '{32'h7b70, 32'h0007, 32'h007f, 32'h0000};
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, rv[i]);
		end
		wb(1'b1, 8'h14, 32'hffff);
		wb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 8'h08, 32'h00ff);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h007f);
		wb(1'b1, 8'h0c, 32'h0055);
		wb(1'b1, 8'h08, 32'h000f);
		repeat (2) @(posedge clk_i);
		chk(32'(discrete_out_o), 32'h05);
		chk(32'(discrete_oe_o), 32'h55);
		bg(24'h0ffffe, 1'b0, 1'b1, 0, 2, 16, 1'b0);
		bg(24'h100000, 1'b0, 1'b1, 0, 0, 0, 1'b0);
	endtask
	// Every lane and direction code against byte, word, read and write accesses
	task t_lane_dir();
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, 8'h00, {16'h0, 1'b0, 2'(k), 2'b11, 1'b0, 4'he, 2'b11, 4'h0});
			bg(24'h10, 1'b1, 1'b1, 0, sx(k[1]), sx(k[1]), 1'b0);
			bg(24'h11, 1'b1, 1'b1, 0, sx(k[0]), sx(k[0]), 1'b0);
			bg(24'h12, 1'b0, 1'b1, 0, sx(k != 0), sx(k != 0), 1'b0);
			wb(1'b1, 8'h00, {16'h0, 3'b011, 2'(k), 1'b0, 4'he, 2'b11, 4'h0});
			bg(24'h14, 1'b0, 1'b1, 0, sx(k[0]), sx(k[0]), 1'b0);
			bg(24'h14, 1'b0, 1'b0, 0, sx(k[1]), sx(k[1]), 1'b0);
		end
	endtask
	// Timing mode and strobe choice with the late strobes two edges behind
	task t_timing();
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, 8'h00, {16'h0, k[1], 4'hf, k[0], 4'he, 2'b11, 4'h0});
			bg(24'h20, 1'b0, 1'b1, 2, k != 0 ? 4 : 2, k != 0 ? 4 : 2, 1'b0);
		end
	endtask
	// All acknowledge codes; the external device answers every select, code 1111 with a delay of 4
	task t_ack();
		for (int c = 0; c < 16; c++) begin
			dly <= 4'(c % 4 + 1);
			wb(1'b1, 8'h00, {16'h0, 6'h1e, 4'(c), 2'b11, 4'h0});
			bg(24'h30, 1'b0, 1'b1, 0, 2, c < 14 ? 3 + c : (c == 14 ? 2 : 0), 1'b0);
		end
	endtask
	// Space and level codes against user data, supervisor program and acknowledge cycles
	task t_space();
		logic u, p, c;
		bus_iack_level_i <= 3'h3;
		bus_iack_pin_i <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			for (int l = 0; l < 8; l++) begin
				u = s[0] && (l == 0 || l == 1 || l == 5);
				p = s[1] && (l == 0 || l == 2 || l == 6);
				c = s == 0 && (l == 0 || l == 3);
				wb(1'b1, 8'h00, {16'h0, 6'h1e, 4'he, 2'(s), 3'(l), l[0]});
				bus_cpu_space_i <= 1'b0;
				bus_super_i <= 1'b0;
				bg(24'h40, 1'b0, 1'b1, 0, sx(u), sx(u), 1'b0);
				bus_super_i <= 1'b1;
				bus_program_i <= 1'b1;
				bg(24'h40, 1'b0, 1'b1, 0, sx(p), sx(p), 1'b0);
				bus_cpu_space_i <= 1'b1;
				bus_program_i <= 1'b0;
				bg(24'h40, 1'b0, 1'b1, 0, sx(c), sx(c), c && l[0]);
			end
		end
	endtask
	task summarize();
		$display("comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, well above the roughly 3400 cycles the scenarios need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end
	// Main sequence
	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, bus_cycle_i, bus_byte_i, bus_read_i, bus_cpu_space_i, bus_program_i} = 8'h00;
		{bus_iack_pin_i, bus_as_i, bus_ds_i, slow_bus_clock_i} = 4'h0;
		bus_super_i = 1'b1;
		adr_i = 8'h00;
		sel_i = 4'h3;
		dat_i = 32'h0;
		bus_addr_i = 24'h0;
		bus_iack_level_i = 3'h0;
		dly = 4'h1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_lane_dir();
		t_timing();
		t_ack();
		t_space();
		summarize();
	end
endmodule
